// ---- logic/dctt_pkg.sv ----
/*
  Shared constants for the down-counting timer with reply time-slot counter:
  register indices and byte addresses, field positions, reset values and the
  prescaler mask function.
  Assumes an APB slave with 8-bit byte addresses and one 32-bit word per register.
*/
package dctt_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] IDX_SEC_STATUS    = 8'h05;
  localparam logic [7:0] IDX_CONTROL       = 8'h09;
  localparam logic [7:0] IDX_COUNT_NOW     = 8'h0c;
  localparam logic [7:0] IDX_TICK_DIV      = 8'h2a;
  localparam logic [7:0] IDX_EVENT_EN      = 8'h2b;
  localparam logic [7:0] IDX_LOAD          = 8'h2c;
  localparam logic [7:0] IDX_SLOT_LOW      = 8'h30;
  localparam logic [7:0] IDX_SIG_OUT_SEL   = 8'h31;
  localparam logic [7:0] IDX_CODER_CFG     = 8'h32;

  localparam logic [7:0] ADDR_SEC_STATUS   = {IDX_SEC_STATUS[5:0], 2'b00};
  localparam logic [7:0] ADDR_CONTROL      = {IDX_CONTROL[5:0], 2'b00};
  localparam logic [7:0] ADDR_COUNT_NOW    = {IDX_COUNT_NOW[5:0], 2'b00};
  localparam logic [7:0] ADDR_TICK_DIV     = {IDX_TICK_DIV[5:0], 2'b00};
  localparam logic [7:0] ADDR_EVENT_EN     = {IDX_EVENT_EN[5:0], 2'b00};
  localparam logic [7:0] ADDR_LOAD         = {IDX_LOAD[5:0], 2'b00};
  localparam logic [7:0] ADDR_SLOT_LOW     = {IDX_SLOT_LOW[5:0], 2'b00};
  localparam logic [7:0] ADDR_SIG_OUT_SEL  = {IDX_SIG_OUT_SEL[5:0], 2'b00};
  localparam logic [7:0] ADDR_CODER_CFG    = {IDX_CODER_CFG[5:0], 2'b00};

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int RUNNING_BIT   = 7;
  localparam int START_NOW_BIT = 1;
  localparam int STOP_NOW_BIT  = 2;
  localparam int AUTO_BIT      = 5;
  localparam int EXP_MSB       = 4;
  localparam int EN_TX_BEGIN   = 0;
  localparam int EN_TX_END     = 1;
  localparam int EN_RX_BEGIN   = 2;
  localparam int EN_RX_END     = 3;
  localparam int SLOT_MSB_BIT  = 0;
  localparam int CODER_MSB     = 2;
  localparam int CRC_EN_BIT    = 7;

  // ****************************************************************
  // Reset values and limits
  // ****************************************************************
  localparam logic [7:0] RST_TICK_DIV   = 8'h00;
  localparam logic [3:0] RST_EVENT_EN   = 4'h0;
  localparam logic [7:0] RST_LOAD       = 8'h00;
  localparam logic [8:0] RST_SLOT       = 9'h000;
  localparam logic [2:0] RST_CODER      = 3'h0;
  localparam logic [4:0] MAX_EXP        = 5'h15;
  localparam int         PRESC_W        = 22;
  localparam logic [4:0] CODER_BASE_EXP = 5'h03;

  typedef enum logic {
    TMR_IDLE = 1'b0,
    TMR_RUN  = 1'b1
  } dctt_timer_state_t;

  // Low bits that must all be ones for a divide-by-two-to-the-exp tick
  function automatic logic [PRESC_W-1:0] dctt_pow2_mask(input logic [4:0] exp_in);
    logic [4:0] e;
    e = (exp_in > MAX_EXP) ? MAX_EXP : exp_in;
    return ~({PRESC_W{1'b1}} << e);
  endfunction

endpackage

// ---- logic/dctt_slot_counter.sv ----
/*
  Reply time-slot counter: after a command frame it counts coder clock periods
  and, at each expiry, triggers transmission of queued data.
  Assumes all inputs come from logic on clock_in.
*/
`timescale 1ns/1ps
module dctt_slot_counter
  import dctt_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  input  wire logic       cmd_end_in,
  input  wire logic [8:0] interval_in,
  input  wire logic [2:0] coder_setting_in,
  input  wire logic       fifo_has_data_in,
  output logic            slot_send_out,
  output logic            slot_active_out
);

  logic [PRESC_W-1:0] cdiv_q;
  logic [8:0]         cnt_q;
  logic               active_q;
  logic               send_q;
  wire  logic [4:0]   coder_exp = CODER_BASE_EXP + {2'b00, coder_setting_in};
  wire  logic [PRESC_W-1:0] cmask = dctt_pow2_mask(coder_exp);
  wire  logic         coder_tick = (cdiv_q & cmask) == cmask;
  wire  logic         arm = cmd_end_in & (interval_in != 9'h000);
  wire  logic         expire = active_q & coder_tick & (cnt_q <= 9'h001) & ~arm;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cdiv_q   <= '0;
      cnt_q    <= RST_SLOT;
      active_q <= 1'b0;
      send_q   <= 1'b0;
    end else begin
      cdiv_q <= arm ? '0 : cdiv_q + 1'b1;
      send_q <= expire & fifo_has_data_in;
      if (arm) begin
        cnt_q    <= interval_in;
        active_q <= 1'b1;
      end else if (expire) begin
        cnt_q    <= interval_in;
        active_q <= interval_in != 9'h000;
      end else if (active_q && coder_tick) begin
        cnt_q <= cnt_q - 9'h001;
      end
    end
  end

  assign slot_send_out   = send_q;
  assign slot_active_out = active_q;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  AST_SLOT_ARM: assert property (arm |=> active_q && cnt_q == $past(interval_in))
    else $error("slot counter not armed at command end");
  AST_SLOT_EMPTY: assert property (expire && !fifo_has_data_in |=> !slot_send_out)
    else $error("send triggered with empty fifo");
  AST_SLOT_ZERO: assert property (expire && interval_in == 9'h000 |=> !active_q)
    else $error("slot counter kept running with zero interval");
  AST_SLOT_RESTART: assert property (expire && interval_in != 9'h000 |=> active_q)
    else $error("slot counter did not restart");

endmodule // dctt_slot_counter

// ---- logic/dctt_timer.sv ----
/*
  Down-counting timer with reply time-slot trigger, APB register slave.
  Assumes framing event inputs are one-cycle pulses from logic on clock_in,
  and clock_in is the chip clock that the prescaler divides.
*/
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module dctt_timer
  import dctt_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        tx_begin_in,
  input  wire logic        tx_end_in,
  input  wire logic        rx_begin_in,
  input  wire logic        rx_end_in,
  input  wire logic        fifo_has_data_in,
  output logic             counting_active_flag_out,
  output logic             expiry_interrupt_request_out,
  output logic      [7:0]  count_now_out,
  output logic             slot_send_out,
  output logic             transmit_checksum_enable_out
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [31:0]        prdata_q;
  logic               pready_q;
  logic               pslverr_q;
  logic [4:0]         tick_divider_exponent_q;
  logic               auto_reload_enable_q;
  logic [3:0]         event_en_q;
  logic [7:0]         load_value_field_q;
  logic [8:0]         reply_slot_interval_q;
  logic [2:0]         coder_clock_setting_q;
  logic               transmit_checksum_enable_q;
  logic [PRESC_W-1:0] presc_q;
  logic [PRESC_W-1:0] presc_d;
  dctt_timer_state_t  state_q;
  dctt_timer_state_t  state_d;
  logic [7:0]         count_q;
  logic [7:0]         count_d;
  logic               irq_q;
  logic               irq_d;
  logic               slot_active;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire logic acc        = psel_in & penable_in;
  // Taken on the first access edge only; the registered pready blocks a repeat
  wire logic rd_take    = acc & ~pready_q;
  wire logic wr_fire    = acc & pready_q & pwrite_in;
  wire logic hit_status = paddr_in == ADDR_SEC_STATUS;
  wire logic hit_ctrl   = paddr_in == ADDR_CONTROL;
  wire logic hit_count  = paddr_in == ADDR_COUNT_NOW;
  wire logic hit_div    = paddr_in == ADDR_TICK_DIV;
  wire logic hit_en     = paddr_in == ADDR_EVENT_EN;
  wire logic hit_load   = paddr_in == ADDR_LOAD;
  wire logic hit_slot   = paddr_in == ADDR_SLOT_LOW;
  wire logic hit_sig    = paddr_in == ADDR_SIG_OUT_SEL;
  wire logic hit_coder  = paddr_in == ADDR_CODER_CFG;
  wire logic mapped     = hit_status | hit_ctrl | hit_count | hit_div | hit_en
                        | hit_load | hit_slot | hit_sig | hit_coder;
  wire logic running    = state_q == TMR_RUN;

  wire logic [7:0] rd_status = {running, 7'h00};
  wire logic [7:0] rd_div    = {2'b00, auto_reload_enable_q, tick_divider_exponent_q};
  wire logic [7:0] rd_coder  = {transmit_checksum_enable_q, 4'h0, coder_clock_setting_q};
  // Control bits are write-one strobes, so the register reads as zero
  wire logic [7:0] rd_byte   =
      hit_status ? rd_status :
      hit_count  ? count_q :
      hit_div    ? rd_div :
      hit_en     ? {4'h0, event_en_q} :
      hit_load   ? load_value_field_q :
      hit_slot   ? reply_slot_interval_q[7:0] :
      hit_sig    ? {7'h00, reply_slot_interval_q[8]} :
      hit_coder  ? rd_coder : 8'h00;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= rd_take;
      pslverr_q <= rd_take & ~mapped;
      prdata_q  <= rd_take ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Configuration writes
  // ****************************************************************
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tick_divider_exponent_q    <= RST_TICK_DIV[EXP_MSB:0];
      auto_reload_enable_q       <= RST_TICK_DIV[AUTO_BIT];
      event_en_q                 <= RST_EVENT_EN;
      load_value_field_q         <= RST_LOAD;
      reply_slot_interval_q      <= RST_SLOT;
      coder_clock_setting_q      <= RST_CODER;
      transmit_checksum_enable_q <= 1'b0;
    end else if (wr_fire) begin
      if (hit_div) begin
        tick_divider_exponent_q <= pwdata_in[EXP_MSB:0];
        auto_reload_enable_q    <= pwdata_in[AUTO_BIT];
      end
      if (hit_en) begin
        event_en_q <= pwdata_in[EN_RX_END:EN_TX_BEGIN];
      end
      if (hit_load) begin
        load_value_field_q <= pwdata_in[7:0];
      end
      if (hit_slot) begin
        reply_slot_interval_q[7:0] <= pwdata_in[7:0];
      end
      if (hit_sig) begin
        reply_slot_interval_q[8] <= pwdata_in[SLOT_MSB_BIT];
      end
      if (hit_coder) begin
        coder_clock_setting_q      <= pwdata_in[CODER_MSB:0];
        transmit_checksum_enable_q <= pwdata_in[CRC_EN_BIT];
      end
    end
  end

  // ****************************************************************
  // Start, stop and tick
  // ****************************************************************
  wire logic sw_start = wr_fire & hit_ctrl & pwdata_in[START_NOW_BIT];
  wire logic sw_stop  = wr_fire & hit_ctrl & pwdata_in[STOP_NOW_BIT];
  wire logic start_w  = sw_start
                      | (tx_begin_in & event_en_q[EN_TX_BEGIN])
                      | (tx_end_in & event_en_q[EN_TX_END]);
  wire logic stop_w   = sw_stop
                      | (rx_begin_in & event_en_q[EN_RX_BEGIN])
                      | (rx_end_in & event_en_q[EN_RX_END]);
  wire logic [PRESC_W-1:0] tmask = dctt_pow2_mask(tick_divider_exponent_q);
  wire logic tick_w   = (presc_q & tmask) == tmask;
  // Acting at one lets auto-reload skip zero and a one-shot land on it
  wire logic at_end   = count_q <= 8'h01;

  // Restarting the prescaler on a start keeps the first period full length
  assign presc_d = start_w ? '0 : presc_q + 1'b1;

  // ****************************************************************
  // Counter state
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    count_d = count_q;
    irq_d   = 1'b0;
    case (state_q)
      TMR_IDLE: begin
        if (start_w) begin
          state_d = TMR_RUN;
          count_d = load_value_field_q;
        end
      end
      TMR_RUN: begin
        if (start_w) begin
          count_d = load_value_field_q;
        end else if (stop_w) begin
          state_d = TMR_IDLE;
        end else if (tick_w && at_end) begin
          irq_d = 1'b1;
          if (auto_reload_enable_q) begin
            count_d = load_value_field_q;
          end else begin
            count_d = 8'h00;
            state_d = TMR_IDLE;
          end
        end else if (tick_w) begin
          count_d = count_q - 8'h01;
        end
      end
      default: begin
        state_d = TMR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      presc_q <= '0;
      state_q <= TMR_IDLE;
      count_q <= 8'h00;
      irq_q   <= 1'b0;
    end else begin
      presc_q <= presc_d;
      state_q <= state_d;
      count_q <= count_d;
      irq_q   <= irq_d;
    end
  end

  // ****************************************************************
  // Reply time slot
  // ****************************************************************
  dctt_slot_counter dctt_slot_counter_inst (
    .clock_in         (clock_in),
    .rst_in           (rst_in),
    .cmd_end_in       (tx_end_in),
    .interval_in      (reply_slot_interval_q),
    .coder_setting_in (coder_clock_setting_q),
    .fifo_has_data_in (fifo_has_data_in),
    .slot_send_out    (slot_send_out),
    .slot_active_out  (slot_active)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata_out                   = prdata_q;
  assign pready_out                   = pready_q;
  assign pslverr_out                  = pslverr_q;
  assign counting_active_flag_out     = running;
  assign expiry_interrupt_request_out = irq_q;
  assign count_now_out                = count_q;
  // The coder appends the CRC8 itself; software should clear this first
  assign transmit_checksum_enable_out = transmit_checksum_enable_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  wire logic quiet = ~start_w & ~stop_w;

  sequence s_count_read;
    rd_take && !pwrite_in && hit_count && quiet && !(running && tick_w && at_end);
  endsequence

  sequence s_last_tick;
    running && tick_w && at_end && quiet;
  endsequence

  AST_START_LOADS: assert property (start_w |=> running && count_q == $past(load_value_field_q))
    else $error("start did not load counter");
  AST_STOP_HALTS: assert property (stop_w && !start_w |=> !running)
    else $error("stop did not halt counter");
  AST_STEP_DOWN: assert property (running && tick_w && !at_end && quiet
                                  |=> count_q == $past(count_q) - 8'h01)
    else $error("counter did not step on tick");
  AST_HOLD_NO_TICK: assert property (running && !tick_w && quiet |=> $stable(count_q))
    else $error("counter moved without tick");
  AST_STOP_NO_IRQ: assert property (running && stop_w && !start_w |=> !irq_q)
    else $error("expiry request after stop event");
  AST_SW_STOP_QUIET: assert property (sw_stop && !start_w |=> !irq_q ##1 !running)
    else $error("software stop raised request");
  AST_ONE_SHOT: assert property ((s_last_tick and !auto_reload_enable_q)
                                 |=> irq_q && !running ##1 !irq_q)
    else $error("one-shot expiry wrong");
  AST_PERIODIC: assert property ((s_last_tick and auto_reload_enable_q)
                                 |=> irq_q && running
                                     && count_q == $past(load_value_field_q))
    else $error("auto reload wrong");
  AST_LOAD_NO_DISTURB: assert property (wr_fire && hit_load && running && quiet && !tick_w
                                        |=> count_q == $past(count_q))
    else $error("load write disturbed count");
  AST_LIVE_READ: assert property (s_count_read
                                  |=> pready_out && prdata_out[7:0] == $past(count_q)
                                      && running == $past(running))
    else $error("count read wrong");
  AST_APB_ONE_WAIT: assert property (rd_take |=> pready_out ##1 !pready_out)
    else $error("apb answer timing wrong");

  // ****************************************************************
  // Register readback and slot checks
  // ****************************************************************
  sequence s_reg_read(hit);
    rd_take && !pwrite_in && hit;
  endsequence

  // A command end re-arms even mid-count, so replies track the latest command
  sequence s_cmd_end_armed;
    tx_end_in && reply_slot_interval_q != 9'h000;
  endsequence

  AST_STATUS_READ: assert property (s_reg_read(hit_status)
                                    |=> prdata_out == {24'h00_0000, $past(running), 7'h00})
    else $error("status read does not show running flag");
  AST_SLOT_MSB_READ: assert property (s_reg_read(hit_sig)
                                      |=> prdata_out == {31'h0, $past(reply_slot_interval_q[8])})
    else $error("slot interval top bit read wrong");
  AST_CTRL_READS_ZERO: assert property (s_reg_read(hit_ctrl) |=> prdata_out == 32'h0000_0000)
    else $error("control strobes read back");
  AST_UNMAPPED_ERR: assert property (rd_take && !mapped
                                     |=> pslverr_out && prdata_out == 32'h0000_0000)
    else $error("unmapped access not refused");
  AST_IDLE_FROZEN: assert property (!running && !start_w |=> !running && $stable(count_q))
    else $error("idle counter moved");
  AST_IDLE_NO_IRQ: assert property (!running |=> !irq_q)
    else $error("expiry request while stopped");
  AST_CHECKSUM_OUT: assert property (wr_fire && hit_coder
                                     |=> transmit_checksum_enable_out
                                         == $past(pwdata_in[CRC_EN_BIT]))
    else $error("checksum enable not taken");
  AST_SLOT_ARMS: assert property (s_cmd_end_armed |=> slot_active)
    else $error("slot counter not armed by command end");
  AST_SLOT_OFF: assert property (!slot_active && reply_slot_interval_q == 9'h000
                                |=> !slot_active && !slot_send_out)
    else $error("slot counter started with zero interval");
  AST_SEND_NEEDS_SLOT: assert property (slot_send_out
                                        |-> $past(slot_active) && $past(fifo_has_data_in))
    else $error("send without active slot and data");
  AST_SEND_ONE_CYCLE: assert property (slot_send_out |=> !slot_send_out)
    else $error("send pulse longer than one cycle");

endmodule // dctt_timer

// ---- verification/dctt_timer_tb.sv ----
/*
  Self-checking bench for dctt_timer: registers over APB, timer events, slot sends.
  Assumes the dctt_pkg constants and the one-wait-state APB slave of the design.
*/
`timescale 1ns/1ps
module dctt_timer_tb;
  import dctt_pkg::*;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic        pready;
  logic        pslverr;
  logic        fifo;
  logic        run;
  logic        irq;
  logic        send;
  logic        crc;
  logic        er;
  logic [3:0]  evt;
  logic [7:0]  paddr;
  logic [7:0]  cnt;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  int          n_errors;
  int          compares;

  dctt_timer dctt_timer_inst (.clock_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .tx_begin_in(evt[0]), .tx_end_in(evt[1]),
    .rx_begin_in(evt[2]), .rx_end_in(evt[3]), .fifo_has_data_in(fifo),
    .counting_active_flag_out(run), .expiry_interrupt_request_out(irq),
    .count_now_out(cnt), .slot_send_out(send), .transmit_checksum_enable_out(crc));

  always #25 clk = ~clk;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // One idle cycle after each transfer keeps psel from being assigned twice in a step
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  task pulse_evt(input logic [3:0] ev);
    evt <= ev;
    @(posedge clk);
    evt <= 4'h0;
  endtask

  task quiet(input int n, output int hits);
    logic [7:0] held;
    @(negedge clk);
    held = cnt;
    hits = 0;
    repeat (n) begin
      @(negedge clk);
      hits += (irq !== 1'b0) + (cnt !== held);
    end
    @(posedge clk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_regs;
    logic [7:0] addrs [9] = '{ADDR_SEC_STATUS, ADDR_CONTROL, ADDR_COUNT_NOW, ADDR_TICK_DIV,
      ADDR_EVENT_EN, ADDR_LOAD, ADDR_SLOT_LOW, ADDR_SIG_OUT_SEL, ADDR_CODER_CFG};
    foreach (addrs[i]) begin
      apb(1'b0, addrs[i], 32'h0);
      chk("reset value", rd, 32'h0);
      chk("mapped error", er, 32'h0);
    end
    apb(1'b0, 8'h00, 32'h0);
    chk("unmapped error", er, 32'h1);
    apb(1'b1, ADDR_LOAD, 32'h5a5);
    apb(1'b0, ADDR_LOAD, 32'h0);
    chk("load readback", rd, 32'ha5);
    apb(1'b1, ADDR_COUNT_NOW, 32'h55);
    apb(1'b0, ADDR_COUNT_NOW, 32'h0);
    chk("count read only", rd, 32'h0);
  endtask

  task t_oneshot;
    apb(1'b1, ADDR_TICK_DIV, 32'h0);
    apb(1'b1, ADDR_LOAD, 32'h3);
    apb(1'b1, ADDR_CONTROL, 32'h2);
    for (int n = 1; n <= 4; n++) begin
      @(negedge clk);
      chk("count", cnt, (n < 3) ? 3 - n : 0);
      chk("running", run, n < 3);
      chk("expiry", irq, n == 3);
    end
    @(posedge clk);
  endtask

  task t_onfly;
    apb(1'b1, ADDR_TICK_DIV, 32'h3);
    apb(1'b1, ADDR_LOAD, 32'h5);
    apb(1'b1, ADDR_CONTROL, 32'h2);
    repeat (9) @(posedge clk);
    apb(1'b0, ADDR_COUNT_NOW, 32'h0);
    chk("count on the fly", rd, 32'h4);
    apb(1'b0, ADDR_SEC_STATUS, 32'h0);
    chk("status running", rd, 32'h80);
  endtask

  task t_swstop;
    int hits;
    apb(1'b1, ADDR_TICK_DIV, 32'h4);
    apb(1'b1, ADDR_LOAD, 32'ha);
    apb(1'b1, ADDR_CONTROL, 32'h2);
    repeat (20) @(posedge clk);
    apb(1'b1, ADDR_CONTROL, 32'h4);
    chk("running", run, 32'h0);
    quiet(200, hits);
    chk("stopped quiet", hits, 32'h0);
  endtask

  task t_rxstop;
    int hits;
    apb(1'b1, ADDR_EVENT_EN, 32'h4);
    apb(1'b1, ADDR_TICK_DIV, 32'h0);
    apb(1'b1, ADDR_LOAD, 32'h28);
    apb(1'b1, ADDR_CONTROL, 32'h2);
    pulse_evt(4'h8);
    @(negedge clk);
    chk("disabled stop", run, 32'h1);
    @(posedge clk);
    pulse_evt(4'h4);
    @(negedge clk);
    chk("receive stop", run, 32'h0);
    @(posedge clk);
    quiet(60, hits);
    chk("stopped quiet", hits, 32'h0);
    apb(1'b1, ADDR_EVENT_EN, 32'h8);
    apb(1'b1, ADDR_CONTROL, 32'h2);
    pulse_evt(4'h8);
    @(negedge clk);
    chk("last bit stop", run, 32'h0);
    @(posedge clk);
  endtask

  task t_auto;
    int k;
    apb(1'b1, ADDR_TICK_DIV, 32'h20);
    apb(1'b1, ADDR_LOAD, 32'h2);
    apb(1'b1, ADDR_CONTROL, 32'h2);
    for (int n = 1; n <= 10; n++) begin
      @(negedge clk);
      k = n + 1;
      chk("auto count", cnt, (k % 2) ? 2 : 1);
      chk("periodic expiry", irq, (k % 2 == 1) && (k >= 3));
    end
    @(posedge clk);
    apb(1'b1, ADDR_CONTROL, 32'h4);
  endtask

  task t_txstart;
    apb(1'b1, ADDR_EVENT_EN, 32'h1);
    apb(1'b1, ADDR_TICK_DIV, 32'h2);
    apb(1'b1, ADDR_LOAD, 32'h4);
    pulse_evt(4'h1);
    @(negedge clk);
    chk("first bit start", {run, cnt}, 9'h104);
    @(posedge clk);
    apb(1'b1, ADDR_LOAD, 32'h9);
    apb(1'b0, ADDR_COUNT_NOW, 32'h0);
    chk("count undisturbed", rd, 32'h3);
    apb(1'b1, ADDR_CONTROL, 32'h2);
    apb(1'b0, ADDR_COUNT_NOW, 32'h0);
    chk("new load used", rd, 32'h9);
    apb(1'b1, ADDR_EVENT_EN, 32'h2);
    apb(1'b1, ADDR_CONTROL, 32'h4);
    pulse_evt(4'h2);
    @(negedge clk);
    chk("last bit start", run, 32'h1);
    @(posedge clk);
  endtask

  // Reset first so a slot counter left armed by the previous case cannot fire
  task t_slot(input logic [8:0] iv, input logic [7:0] cfg, input logic f, input int first,
              input int per, input int len);
    int hits;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b1, ADDR_SLOT_LOW, {24'h0, iv[7:0]});
    apb(1'b1, ADDR_SIG_OUT_SEL, {31'h0, iv[8]});
    apb(1'b1, ADDR_CODER_CFG, {24'h0, cfg});
    chk("checksum enable", crc, cfg[7]);
    fifo <= f;
    pulse_evt(4'h2);
    hits = 0;
    for (int n = 1; n <= len; n++) begin
      @(negedge clk);
      hits += (send !== (f && first > 0 && n >= first && (n - first) % per == 0));
    end
    chk("slot sends", hits, 32'h0);
    @(posedge clk);
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    evt = 4'h0;
    fifo = 1'b0;
    n_errors = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_oneshot;
    t_onfly;
    t_swstop;
    t_rxstop;
    t_auto;
    t_txstart;
    t_slot(9'h002, 8'h00, 1'b1, 17, 16, 40);
    t_slot(9'h002, 8'h01, 1'b1, 33, 32, 70);
    t_slot(9'h002, 8'h00, 1'b0, 17, 16, 40);
    t_slot(9'h000, 8'h00, 1'b1, 0, 1, 60);
    t_slot(9'h100, 8'h80, 1'b1, 2049, 2048, 2060);
    give_verdict;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict;
  end
endmodule // dctt_timer_tb
